// ==== hw/dual_slope_ratio_sequencer.sv ====
// Charge/discharge sequencer and counter for the ratio converter
module dual_slope_ratio_sequencer #(
  // Count clock divider; override only to shorten simulations
  parameter logic [11:0] TICK_DIV = ratio_seq_pkg::COUNT_DIV
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic start, // Begin a conversion, one-cycle pulse
  input wire ratio_seq_pkg::mode_e mode, // Conversion kind
  input wire logic testPeriodTick, // Async test-signal period marker
  input wire logic zeroCross, // Async integrator zero indication
  output ratio_seq_pkg::afe_ctrl_s afeCtrl, // Front-end controls
  output ratio_seq_pkg::result_s result, // Held conversion result
  output logic busy // Conversion in progress
);
  typedef struct packed {
    ratio_seq_pkg::state_e state;
    ratio_seq_pkg::mode_e mode;
    logic [15:0] timer;
    ratio_seq_pkg::afe_ctrl_s afe;
    ratio_seq_pkg::result_s res;
    logic busy;
  } st_s;

  st_s s_q;
  st_s s_d;
  logic tpEdge;
  logic zcEdge;
  logic chargeEnd;
  logic countTick;

  // Count clock as a one-cycle tick, free running
  count_clock_div #(
    .DIV(TICK_DIV)
  ) u_count_div (
    .clk(clk),
    .rst(rst),
    .tick(countTick)
  );

  // Both front-end signals are asynchronous to clk
  edge_sync u_tp_sync (
    .clk(clk),
    .rst(rst),
    .pin(testPeriodTick),
    .rise(tpEdge)
  );

  edge_sync u_zc_sync (
    .clk(clk),
    .rst(rst),
    .pin(zeroCross),
    .rise(zcEdge)
  );

  always_comb begin
    s_d = s_q;
    chargeEnd = 1'b0;
    case (s_q.mode)
      ratio_seq_pkg::MODE_PARALLEL:
        chargeEnd = tpEdge && (s_q.timer[7:0] ==
          ratio_seq_pkg::PARALLEL_PERIODS - 8'h01);
      ratio_seq_pkg::MODE_SERIES:
        chargeEnd = tpEdge && (s_q.timer[7:0] ==
          ratio_seq_pkg::SERIES_PERIODS - 8'h01);
      default:
        chargeEnd = countTick && (s_q.timer ==
          ratio_seq_pkg::LOSS_CHARGE_COUNTS - 16'h0001);
    endcase
    case (s_q.state)
      ratio_seq_pkg::ST_IDLE, ratio_seq_pkg::ST_DONE: begin
        s_d.afe.integrate = 1'b0;
        s_d.busy = 1'b0;
        if (start) begin
          s_d.mode = mode;
          s_d.timer = ratio_seq_pkg::COUNT_RESET;
          s_d.state = ratio_seq_pkg::ST_CHARGE;
          s_d.busy = 1'b1;
          s_d.afe.integrate = 1'b1;
          case (mode)
            ratio_seq_pkg::MODE_SERIES: begin
              s_d.afe.refFromRange = 1'b1;
              s_d.afe.inputIsDut = 1'b1;
              s_d.afe.phase = ratio_seq_pkg::PH_0;
            end
            ratio_seq_pkg::MODE_LOSS: begin
              s_d.afe.refFromRange = 1'b1;
              s_d.afe.inputIsDut = 1'b0;
              s_d.afe.phase = ratio_seq_pkg::PH_0;
            end
            default: begin
              s_d.afe.refFromRange = 1'b0;
              s_d.afe.inputIsDut = 1'b0;
              s_d.afe.phase = ratio_seq_pkg::PH_90;
            end
          endcase
        end
      end
      ratio_seq_pkg::ST_CHARGE: begin
        if (s_q.mode == ratio_seq_pkg::MODE_LOSS) begin
          if (countTick) begin
            s_d.timer = s_q.timer + 16'h0001;
          end
        end else if (tpEdge) begin
          s_d.timer = s_q.timer + 16'h0001;
        end
        if (chargeEnd) begin
          s_d.state = ratio_seq_pkg::ST_DISCHARGE;
          s_d.timer = ratio_seq_pkg::COUNT_RESET;
          case (s_q.mode)
            ratio_seq_pkg::MODE_SERIES: begin
              s_d.afe.phase = ratio_seq_pkg::PH_90;
            end
            ratio_seq_pkg::MODE_LOSS: begin
              s_d.afe.phase = ratio_seq_pkg::PH_90;
            end
            default: begin
              s_d.afe.inputIsDut = 1'b1;
              s_d.afe.phase = ratio_seq_pkg::PH_0;
            end
          endcase
        end
      end
      ratio_seq_pkg::ST_DISCHARGE: begin
        if (zcEdge) begin
          s_d.state = ratio_seq_pkg::ST_DONE;
          s_d.afe.integrate = 1'b0;
          s_d.busy = 1'b0;
          s_d.res.count = s_q.timer;
          s_d.res.valid = 1'b1;
          s_d.res.decPoint = (s_q.mode == ratio_seq_pkg::MODE_LOSS) ?
            ratio_seq_pkg::DP_LOSS : ratio_seq_pkg::DP_CAP;
        end else if (countTick && s_q.timer != ratio_seq_pkg::COUNT_SAT) begin
          s_d.timer = s_q.timer + 16'h0001;
        end
      end
      default: begin
        s_d.state = ratio_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign afeCtrl = s_q.afe;
  assign result = s_q.res;
  assign busy = s_q.busy;
endmodule // dual_slope_ratio_sequencer

// Two-flop synchroniser with a rising-edge detector behind it
module edge_sync (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic pin, // Asynchronous level from the front end
  output logic rise // High for one cycle per rising edge
);
  typedef struct packed {
    logic [1:0] sync;
    logic prev;
  } st_s;

  st_s s_q;
  st_s s_d;

  always_comb begin
    s_d = s_q;
    // Stage 0 may be metastable, so only stage 1 reads it
    s_d.sync = {s_q.sync[0], pin};
    s_d.prev = s_q.sync[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Reset level matches the idle pin, so no edge follows reset
  assign rise = s_q.sync[1] & ~s_q.prev;
endmodule // edge_sync

// Divides clk down to the count clock as a one-cycle tick
module count_clock_div #(
  parameter logic [11:0] DIV = ratio_seq_pkg::COUNT_DIV // Clocks per tick
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  output logic tick // One cycle high per count period
);
  typedef struct packed {
    logic [11:0] div;
    logic tick;
  } st_s;

  st_s s_q;
  st_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.div == DIV - 12'h001) begin
      s_d.div = 12'h000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 12'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Registered so every reader sees a clean one-cycle tick
  assign tick = s_q.tick;
endmodule // count_clock_div

// ==== hw/ratio_seq_pkg.sv ====
// Shared types and constants for the dual-slope ratio sequencer
package ratio_seq_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // Count clock 31.83 kHz, taken as a divided system clock
  localparam int unsigned COUNT_CLOCK_HZ = 31830;
  localparam logic [11:0] COUNT_DIV = 12'(CLK_HZ / COUNT_CLOCK_HZ);
  localparam logic [15:0] LOSS_CHARGE_COUNTS = 16'h03E8; // 1000
  localparam logic [7:0] PARALLEL_PERIODS = 8'h32; // 50 at 1 kHz
  localparam logic [7:0] SERIES_PERIODS = 8'h05; // 5 at 1 kHz
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0] DP_LOSS = 3'h3; // Three digits after the point
  localparam logic [2:0] DP_CAP = 3'h0; // Capacitance mantissa, no point
  localparam logic [15:0] COUNT_SAT = 16'hFFFF; // Counter stops here

  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_SERIES = 2'b01,
    MODE_LOSS = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHARGE = 3'b001,
    ST_DISCHARGE = 3'b010,
    ST_DONE = 3'b011
  } state_e;

  // Phase codes: 0, 90, 180, 270 degrees from the selected reference
  typedef enum logic [1:0] {
    PH_0 = 2'b00,
    PH_90 = 2'b01,
    PH_180 = 2'b10,
    PH_270 = 2'b11
  } phase_e;

  // Analog front-end control bundle
  typedef struct packed {
    logic refFromRange;   // Phase reference taken from range_voltage
    logic inputIsDut;     // Detector input is dut_voltage / 10
    phase_e phase;        // Chosen detection phase
    logic integrate;      // Integrator connected
  } afe_ctrl_s;

  typedef struct packed {
    logic [15:0] count;   // Mantissa or 1000*D
    logic [2:0] decPoint; // Digits right of the decimal point
    logic valid;
  } result_s;
endpackage

// ==== tb/ratio_seq_sva.sv ====
// Port checker for the ratio sequencer
module ratio_seq_sva (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic start, // Start
  input wire ratio_seq_pkg::mode_e mode, // Mode
  input wire logic testPeriodTick, // Tick
  input wire logic zeroCross, // Zero
  input wire ratio_seq_pkg::afe_ctrl_s afeCtrl, // Controls
  input wire ratio_seq_pkg::result_s result, // Result
  input wire logic busy // Busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take, par, ser, lss, loss_q;
  assign take = start && !busy;
  assign par = take && mode == ratio_seq_pkg::MODE_PARALLEL;
  assign ser = take && mode == ratio_seq_pkg::MODE_SERIES;
  assign lss = take && mode == ratio_seq_pkg::MODE_LOSS;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) loss_q <= 1'b0;
    else if (take) loss_q <= lss;
  end
  a_start_busy: assert property (take |=> busy && afeCtrl.integrate)
    else $error("no busy after start");
  a_par_charge: assert property (par |=> afeCtrl == 5'h03)
    else $error("parallel charge");
  a_ser_charge: assert property (ser |=> afeCtrl == 5'h19)
    else $error("series charge");
  a_loss_charge: assert property (lss |=> afeCtrl[3:0] == 4'h1)
    else $error("loss charge");
  a_disch_cfg: assert property (
    busy && $past(busy) && $changed(afeCtrl) |-> afeCtrl.integrate &&
    afeCtrl.phase == (afeCtrl[4:3] == 2'b01 ? 2'h0 : 2'h1))
    else $error("discharge config");
  a_done_valid: assert property ($fell(busy) |-> result.valid)
    else $error("no valid");
  a_done_point: assert property ($fell(busy) |->
    result.decPoint == (loss_q ? 3'h3 : 3'h0)) else $error("point");
  a_hold_res: assert property (busy |-> $stable(result))
    else $error("result moved");
  a_idle_int: assert property (!busy |-> !afeCtrl.integrate)
    else $error("integrate while idle");
  c_par: cover property (par);
  c_ser: cover property (ser);
  c_done: cover property ($fell(busy));
  c_loss: cover property ($fell(busy) && loss_q);
endmodule // ratio_seq_sva

bind dual_slope_ratio_sequencer ratio_seq_sva u_sva (.*);

// ==== tb/afe_model.sv ====
// Behavioural analog front end: period marker and zero detector
module afe_model #(
  // Half a count period past 3, so either divider phase is legal
  parameter int FIRE = 13745
) (
  input wire logic clk, // Clock
  input wire ratio_seq_pkg::afe_ctrl_s afeCtrl, // Controls
  output logic testPeriodTick, // Period marker
  output logic zeroCross // Zero indication
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  ratio_seq_pkg::afe_ctrl_s last;
  initial begin
    testPeriodTick = 1'b0;
    // Test period scaled to 40 clocks to keep runs short
    forever #160 testPeriodTick = !testPeriodTick;
  end
  // Falling edge, like the rest of the stimulus
  always @(negedge clk) begin
    last <= afeCtrl;
    if (!afeCtrl.integrate) cnt <= -1;
    else if (afeCtrl != last && last.integrate) cnt <= 0;
    else if (cnt >= 0) cnt <= cnt + 1;
    zeroCross <= cnt == FIRE;
  end
endmodule // afe_model

// ==== tb/tb.sv ====
// Self-checking bench for the ratio sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short count clock so a full loss cycle fits the run
  localparam logic [11:0] DIV = 12'h00C;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0;
  logic busy, testPeriodTick, zeroCross;
  ratio_seq_pkg::mode_e mode = ratio_seq_pkg::MODE_PARALLEL;
  ratio_seq_pkg::afe_ctrl_s afeCtrl;
  ratio_seq_pkg::result_s result;
  int fails = 0, samplesChecked = 0, len;
  dual_slope_ratio_sequencer #(.TICK_DIV(DIV)) u_dut (.clk(clk), .rst(rst),
    .start(start), .mode(mode), .testPeriodTick(testPeriodTick),
    .zeroCross(zeroCross), .afeCtrl(afeCtrl), .result(result), .busy(busy));
  afe_model #(.FIRE(DIV * 7 / 2)) u_afe (.clk(clk), .afeCtrl(afeCtrl),
    .testPeriodTick(testPeriodTick), .zeroCross(zeroCross));
  initial begin
    forever #4 clk = !clk;
  end
  task automatic print_verdict();
    if (fails == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [19:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int lim);
    if (len > lim) begin
      fails++;
      $display("[ERR] timeout expected %0d seen %0d", lim, len);
      print_verdict();
    end else begin
      len++;
      @(negedge clk);
    end
  endtask
  task automatic go(ratio_seq_pkg::mode_e m);
    mode = m;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
  endtask
  task automatic capScn(ratio_seq_pkg::mode_e m, logic [19:0] ce, de,
    logic [3:0] fl, int n);
    ratio_seq_pkg::afe_ctrl_s c;
    int d;
    logic [15:0] k;
    go(m);
    chk("chargeCfg", ce, 20'(afeCtrl));
    c = afeCtrl;
    go(ratio_seq_pkg::MODE_LOSS);
    chk("ignoredStart", ce, 20'(afeCtrl));
    for (len = 4; afeCtrl === c; ) tick(n + 1000);
    d = len - n;
    chk("chargeLen", 20'h1, 20'(d * d < 2500));
    chk("dischargeCfg", de, 20'(afeCtrl));
    for (len = 0; busy !== 1'b0; ) tick(20000);
    // Model fires 3.5 count periods in, so 3 or 4 counts
    k = result.count - 16'h3;
    chk("count", 20'h1, 20'(k < 16'h2));
    chk("flags", 20'(fl), 20'({result.decPoint, result.valid}));
  endtask
  task automatic lossScn();
    go(ratio_seq_pkg::MODE_LOSS);
    repeat (2500) @(negedge clk);
    chk("lossCfg", 20'h1, 20'(afeCtrl[3:0]));
    rst = 1'b1;
    @(negedge clk);
    chk("resetCtl", 20'h0, 20'({busy, afeCtrl}));
    chk("resetRes", 20'h0, result);
    rst = 1'b0;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    capScn(ratio_seq_pkg::MODE_PARALLEL, 20'h03, 20'h09, 4'h1,
      50 * 40);
    capScn(ratio_seq_pkg::MODE_SERIES, 20'h19, 20'h1B, 4'h1,
      5 * 40);
    lossScn();
    capScn(ratio_seq_pkg::MODE_LOSS, 20'h11, 20'h13, 4'h7,
      1000 * DIV);
    print_verdict();
  end
endmodule // tb
